// ### core/dmscp_pkg.sv
// Constants and types shared by the dual-mode serial configuration port
package dmscp_pkg;

  // Four-level strap codes delivered by the strap comparators
  typedef enum logic [1:0] {
    DMSCP_LVL_L = 2'h0,
    DMSCP_LVL_R = 2'h1,
    DMSCP_LVL_F = 2'h2,
    DMSCP_LVL_H = 2'h3
  } dmscp_level_type;

  // Slave address map
  localparam logic [6:0] DMSCP_SLAVE_ADDR_BASE = 7'h1D;

  // SPI frame layout
  localparam int         DMSCP_FRAME_BITS = 17;
  localparam int         DMSCP_DIR_POS    = 16;
  localparam int         DMSCP_ADDR_POS   = 8;
  localparam int         DMSCP_DATA_POS   = 0;
  localparam logic [4:0] DMSCP_FRAME_LEN  = 5'h11;
  localparam logic [4:0] DMSCP_CNT_MAX    = 5'h1F;

  // Page select register
  localparam logic [7:0] DMSCP_PAGE_REG_ADDR = 8'hFF;
  localparam logic [7:0] DMSCP_PAGE_RESET    = 8'h00;
  localparam int         DMSCP_PAGE_EN_POS   = 2;
  localparam logic [1:0] DMSCP_PAGE_SEL_EQ   = 2'h1;

  // Cycles after reset release before straps are caught
  localparam logic [2:0] DMSCP_STRAP_SETTLE  = 3'h4;

endpackage : dmscp_pkg

// ### core/dmscp_spi_link.sv
// SPI shift register running on the serial clock of the link
`timescale 1ns/1ps
module dmscp_spi_link
  import dmscp_pkg::*;
(
  // Link clock and reset
  input  wire logic        sck,
  input  wire logic        resetn,
  // Link pins
  input  wire logic        ss_n,
  input  wire logic        mosi,
  output logic             miso,
  // Reply from the register side, changed only after select rises
  input  wire logic [16:0] reply_word,
  input  wire logic        reply_tog,
  // Frame state, read by the register side after select rises
  output logic [16:0] frame_word,
  output logic [4:0]  frame_cnt,
  output logic        frame_tog,
  output logic        reply_ack_tog
);

  logic [16:0] shift_r, shift_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  logic        ack_r, ack_nxt;
  logic        tog_r, tog_nxt;
  logic        fresh_r;
  logic        load_pend;

  // Reply pending until the first clock of the next frame takes it
  assign load_pend = reply_tog ^ ack_r;

  // Next shift state; a frame's first edge restarts the count and may load a reply
  always_comb begin
    shift_nxt = {shift_r[15:0], mosi};
    ack_nxt   = ack_r;
    tog_nxt   = tog_r;
    cnt_nxt   = (cnt_r == DMSCP_CNT_MAX) ? cnt_r : cnt_r + 5'h1;
    if (ss_n) begin
      shift_nxt = shift_r;
      cnt_nxt   = cnt_r;
    end else if (fresh_r) begin
      cnt_nxt = 5'h1;
      tog_nxt = !tog_r;
      if (load_pend) begin
        shift_nxt = {reply_word[15:0], mosi};
        ack_nxt   = reply_tog;
      end
    end
  end

  // Count and frame toggle stand after select rises, for the register side
  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      shift_r <= 17'h0_0000;
      cnt_r   <= 5'h0;
      ack_r   <= 1'b0;
      tog_r   <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
      ack_r   <= ack_nxt;
      tog_r   <= tog_nxt;
    end
  end

  // Frame start flag: held set while select is high, cleared by the first clock
  always_ff @(posedge sck or negedge resetn or posedge ss_n) begin
    if (!resetn || ss_n) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  // Output is the head of the register, or of a reply not yet loaded
  assign miso          = (fresh_r && load_pend) ? reply_word[16] : shift_r[16];
  assign frame_word    = shift_r;
  assign frame_cnt     = cnt_r;
  assign frame_tog     = tog_r;
  assign reply_ack_tog = ack_r;

  property p_shift_in;
    @(posedge sck) disable iff (!resetn || ss_n)
    !fresh_r |=> shift_r[0] == $past(mosi) && shift_r[16:1] == $past(shift_r[15:0]);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift lost a bit");

  property p_reply_load;
    @(posedge sck) disable iff (!resetn || ss_n)
    fresh_r && load_pend |=> shift_r[16:1] == $past(reply_word[15:0]) && !load_pend;
  endproperty
  a_reply_load: assert property (p_reply_load) else $error("reply not loaded");

  property p_frame_start;
    @(posedge sck) disable iff (!resetn || ss_n)
    fresh_r |=> cnt_r == 5'h1 && frame_tog != $past(frame_tog);
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame start lost");

endmodule : dmscp_spi_link

// ### core/dmscp_top.sv
// Dual-mode serial configuration port: straps, two-wire slave, SPI, pages
`timescale 1ns/1ps
module dmscp_top
  import dmscp_pkg::*;
(
  // System clock and power-up reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Strap levels
  input  wire logic [1:0] mode_strap,
  input  wire logic [1:0] slave_id_strap_a,
  input  wire logic [1:0] slave_id_strap_b,
  // Two-wire pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // SPI pins
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  output logic            miso_o,
  output logic            miso_oe,
  // Mode status
  output logic            smbus_mode,
  output logic            spi_mode,
  output logic            low_power,
  output logic            eq_page_active
);
  import dmscp_pkg::*;

  typedef enum {
    SM_IDLE, SM_DEV, SM_ACK_DEV, SM_REG, SM_ACK_REG, SM_WDATA, SM_ACK_DATA,
    SM_RDATA, SM_RACK, SM_IGNORE
  } dmscp_sm_type;

  // Register storage of the two pages
  logic [7:0] shared_mem [0:255];
  logic [7:0] eq_mem     [0:255];
  logic [7:0] page_r, page_nxt;

  // Page decode, used by the read path and status
  function automatic logic page_is_eq(input logic [7:0] pg);
    page_is_eq = pg[DMSCP_PAGE_EN_POS] && pg[1:0] == DMSCP_PAGE_SEL_EQ;
  endfunction

  // Register read, 0xFF always reaches the page register
  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] pg,
                                          input logic [7:0] sh, input logic [7:0] eq);
    if (a == DMSCP_PAGE_REG_ADDR) begin
      reg_read = pg;
    end else if (page_is_eq(pg)) begin
      reg_read = eq;
    end else begin
      reg_read = sh;
    end
  endfunction

  // ---------------- Strap capture ----------------
  logic [1:0] mode_s1, mode_s2, ida_s1, ida_s2, idb_s1, idb_s2;
  logic [2:0] settle_r, settle_nxt;
  logic       strap_done_r, strap_done_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [6:0] slave_addr_r, slave_addr_nxt;

  // Two-stage synchronisers for strap pins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode_s1 <= 2'h0;
      mode_s2 <= 2'h0;
      ida_s1  <= 2'h0;
      ida_s2  <= 2'h0;
      idb_s1  <= 2'h0;
      idb_s2  <= 2'h0;
    end else begin
      mode_s1 <= mode_strap;
      mode_s2 <= mode_s1;
      ida_s1  <= slave_id_strap_a;
      ida_s2  <= ida_s1;
      idb_s1  <= slave_id_strap_b;
      idb_s2  <= idb_s1;
    end
  end

  // Straps are caught once after release and then held
  always_comb begin
    settle_nxt     = settle_r;
    strap_done_nxt = strap_done_r;
    mode_nxt       = mode_r;
    slave_addr_nxt = slave_addr_r;
    if (!strap_done_r) begin
      settle_nxt = settle_r + 3'h1;
      if (settle_r == DMSCP_STRAP_SETTLE) begin
        strap_done_nxt = 1'b1;
        mode_nxt       = mode_s2;
        slave_addr_nxt = DMSCP_SLAVE_ADDR_BASE + {3'h0, ida_s2, idb_s2};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      settle_r     <= 3'h0;
      strap_done_r <= 1'b0;
      mode_r       <= 2'h1;
      slave_addr_r <= 7'h00;
    end else begin
      settle_r     <= settle_nxt;
      strap_done_r <= strap_done_nxt;
      mode_r       <= mode_nxt;
      slave_addr_r <= slave_addr_nxt;
    end
  end

  // Mode decode; level R enables neither port
  assign smbus_mode = strap_done_r && mode_r == DMSCP_LVL_L;
  assign spi_mode   = strap_done_r && (mode_r == DMSCP_LVL_F || mode_r == DMSCP_LVL_H);
  assign low_power  = strap_done_r && mode_r == DMSCP_LVL_H;

  // ---------------- Two-wire slave ----------------
  logic         scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic         scl_rise, scl_fall, start_c, stop_c;
  dmscp_sm_type sm_r, sm_nxt;
  logic [3:0]   bit_r, bit_nxt;
  logic [7:0]   sh_r, sh_nxt, ptr_r, ptr_nxt, tx_r, tx_nxt;
  logic         dir_r, dir_nxt, drv_r, drv_nxt;
  logic         sm_wr;

  // Pin synchronisers and one extra stage for edges
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 && !scl_d;
  assign scl_fall = !scl_s2 && scl_d;
  assign start_c  = scl_s2 && scl_d && !sda_s2 && sda_d;
  assign stop_c   = scl_s2 && scl_d && sda_s2 && !sda_d;

  // Byte engine: sample on rise, act and drive on fall
  always_comb begin
    sm_nxt  = sm_r;
    bit_nxt = bit_r;
    sh_nxt  = sh_r;
    ptr_nxt = ptr_r;
    tx_nxt  = tx_r;
    dir_nxt = dir_r;
    drv_nxt = drv_r;
    sm_wr   = 1'b0;
    if (!smbus_mode || stop_c) begin
      sm_nxt  = SM_IDLE;
      drv_nxt = 1'b0;
    end else if (start_c) begin
      sm_nxt  = SM_DEV;
      bit_nxt = 4'h0;
      drv_nxt = 1'b0;
    end else if (scl_rise) begin
      if (sm_r == SM_DEV || sm_r == SM_REG || sm_r == SM_WDATA) begin
        sh_nxt  = {sh_r[6:0], sda_s2};
        bit_nxt = bit_r + 4'h1;
      end
    end else if (scl_fall) begin
      case (sm_r)
        SM_DEV: begin
          if (bit_r == 4'h8) begin
            if (sh_r[7:1] == slave_addr_r) begin
              sm_nxt  = SM_ACK_DEV;
              dir_nxt = sh_r[0];
              drv_nxt = 1'b1;
            end else begin
              sm_nxt  = SM_IGNORE;
            end
          end
        end
        SM_ACK_DEV: begin
          bit_nxt = 4'h0;
          if (dir_r) begin
            tx_nxt  = reg_read(ptr_r, page_r, shared_mem[ptr_r], eq_mem[ptr_r]);
            drv_nxt = !tx_nxt[7];
            sm_nxt  = SM_RDATA;
          end else begin
            drv_nxt = 1'b0;
            sm_nxt  = SM_REG;
          end
        end
        SM_REG: begin
          if (bit_r == 4'h8) begin
            ptr_nxt = sh_r;
            drv_nxt = 1'b1;
            sm_nxt  = SM_ACK_REG;
          end
        end
        SM_ACK_REG: begin
          drv_nxt = 1'b0;
          bit_nxt = 4'h0;
          sm_nxt  = SM_WDATA;
        end
        SM_WDATA: begin
          if (bit_r == 4'h8) begin
            sm_wr   = 1'b1;
            drv_nxt = 1'b1;
            sm_nxt  = SM_ACK_DATA;
          end
        end
        SM_ACK_DATA: begin
          drv_nxt = 1'b0;
          sm_nxt  = SM_IGNORE;
        end
        SM_RDATA: begin
          if (bit_r == 4'h7) begin
            drv_nxt = 1'b0;
            sm_nxt  = SM_RACK;
          end else begin
            tx_nxt  = {tx_r[6:0], 1'b0};
            drv_nxt = !tx_r[6];
            bit_nxt = bit_r + 4'h1;
          end
        end
        SM_RACK: begin
          sm_nxt = SM_IGNORE;
        end
        SM_IDLE, SM_IGNORE: begin
          drv_nxt = 1'b0;
        end
        default: begin
          sm_nxt  = SM_IDLE;
          drv_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sm_r  <= SM_IDLE;
      bit_r <= 4'h0;
      sh_r  <= 8'h00;
      ptr_r <= 8'h00;
      tx_r  <= 8'h00;
      dir_r <= 1'b0;
      drv_r <= 1'b0;
    end else begin
      sm_r  <= sm_nxt;
      bit_r <= bit_nxt;
      sh_r  <= sh_nxt;
      ptr_r <= ptr_nxt;
      tx_r  <= tx_nxt;
      dir_r <= dir_nxt;
      drv_r <= drv_nxt;
    end
  end

  // Open drain: only ever pull low
  assign sda_o  = 1'b0;
  assign sda_oe = drv_r;

  // ---------------- SPI port ----------------
  logic [16:0] frame_word, reply_r, reply_nxt;
  logic [4:0]  frame_cnt;
  logic        reply_tog_r, reply_tog_nxt, ack_tog, miso_raw;
  logic        frame_tog, seen_tog_r, seen_tog_nxt, new_frame;
  logic        ss_s1, ss_s2, ss_d, ss_rise;
  logic        spi_wr, spi_rd;

  dmscp_spi_link u_link (
    .sck           (sck),
    .resetn        (resetn),
    .ss_n          (ss_n),
    .mosi          (mosi),
    .miso          (miso_raw),
    .reply_word    (reply_r),
    .reply_tog     (reply_tog_r),
    .frame_word    (frame_word),
    .frame_cnt     (frame_cnt),
    .frame_tog     (frame_tog),
    .reply_ack_tog (ack_tog)
  );

  // Select synchroniser and rising-edge detect
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ss_s1 <= 1'b1;
      ss_s2 <= 1'b1;
      ss_d  <= 1'b1;
    end else begin
      ss_s1 <= ss_n;
      ss_s2 <= ss_s1;
      ss_d  <= ss_s2;
    end
  end

  assign ss_rise = ss_s2 && !ss_d;
  // A select pulse without clocks must not replay the previous frame
  assign new_frame = frame_tog != seen_tog_r;
  // Frame state is quiet once select is high; only new full frames act
  assign spi_wr = spi_mode && ss_rise && new_frame && frame_cnt == DMSCP_FRAME_LEN &&
                  !frame_word[DMSCP_DIR_POS];
  assign spi_rd = spi_mode && ss_rise && new_frame && frame_cnt == DMSCP_FRAME_LEN &&
                  frame_word[DMSCP_DIR_POS];

  // Read request prepares the reply for the next frame
  always_comb begin
    reply_nxt     = reply_r;
    reply_tog_nxt = reply_tog_r;
    seen_tog_nxt  = ss_rise ? frame_tog : seen_tog_r;
    if (spi_rd) begin
      reply_nxt = {1'b1, frame_word[15:8],
                   reg_read(frame_word[15:8], page_r, shared_mem[frame_word[15:8]],
                            eq_mem[frame_word[15:8]])};
      reply_tog_nxt = !reply_tog_r;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reply_r     <= 17'h0_0000;
      reply_tog_r <= 1'b0;
      seen_tog_r  <= 1'b0;
    end else begin
      reply_r     <= reply_nxt;
      reply_tog_r <= reply_tog_nxt;
      seen_tog_r  <= seen_tog_nxt;
    end
  end

  // Driver follows select with no clock in the path
  assign miso_oe = spi_mode && !ss_n;
  assign miso_o  = miso_raw;

  // ---------------- Register write port ----------------
  logic       wr_en;
  logic [7:0] wr_addr, wr_data;

  assign wr_en   = sm_wr || spi_wr;
  assign wr_addr = sm_wr ? ptr_r : frame_word[15:8];
  assign wr_data = sm_wr ? sh_r  : frame_word[7:0];

  // Page register
  always_comb begin
    page_nxt = page_r;
    if (wr_en && wr_addr == DMSCP_PAGE_REG_ADDR) begin
      page_nxt = wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      page_r <= DMSCP_PAGE_RESET;
    end else begin
      page_r <= page_nxt;
    end
  end

  // Page storage, written to the page the page register selects
  always_ff @(posedge ref_clk) begin
    if (wr_en && wr_addr != DMSCP_PAGE_REG_ADDR) begin
      if (page_is_eq(page_r)) begin
        eq_mem[wr_addr] <= wr_data;
      end else begin
        shared_mem[wr_addr] <= wr_data;
      end
    end
  end

  assign eq_page_active = page_is_eq(page_r);

  // ---------------- Checks ----------------
  property p_addr_map;
    @(posedge ref_clk) disable iff (!resetn)
    $rose(strap_done_r) |->
      slave_addr_r == DMSCP_SLAVE_ADDR_BASE + {3'h0, $past(ida_s2), $past(idb_s2)};
  endproperty
  a_addr_map: assert property (p_addr_map) else $error("slave address map wrong");

  property p_strap_hold;
    @(posedge ref_clk) disable iff (!resetn)
    strap_done_r |=> strap_done_r && $stable(mode_r) && $stable(slave_addr_r);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

  property p_nack_foreign;
    @(posedge ref_clk) disable iff (!resetn)
    sm_r == SM_DEV && scl_fall && bit_r == 4'h8 && sh_r[7:1] != slave_addr_r && !start_c && !stop_c
    |=> !sda_oe [*3];
  endproperty
  a_nack_foreign: assert property (p_nack_foreign) else $error("acked foreign address");

  property p_ack_own;
    @(posedge ref_clk) disable iff (!resetn)
    smbus_mode && sm_r == SM_DEV && scl_fall && bit_r == 4'h8 && sh_r[7:1] == slave_addr_r &&
    !start_c && !stop_c |=> sda_oe && sm_r == SM_ACK_DEV;
  endproperty
  a_ack_own: assert property (p_ack_own) else $error("no ack for own address");

  property p_open_drain;
    @(posedge ref_clk) disable iff (!resetn)
    sda_oe |-> sda_o == 1'b0 && smbus_mode;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven high");

  property p_miso_enable;
    @(posedge ref_clk) disable iff (!resetn)
    spi_mode |-> miso_oe == !ss_n;
  endproperty
  a_miso_enable: assert property (p_miso_enable) else $error("miso enable wrong");

  property p_write_at_rise;
    @(posedge ref_clk) disable iff (!resetn)
    spi_wr |-> (ss_s2 && !ss_d) ##1
      (page_r == $past(wr_data) || $past(wr_addr) != DMSCP_PAGE_REG_ADDR);
  endproperty
  a_write_at_rise: assert property (p_write_at_rise) else $error("spi write misplaced");

  property p_page_switch;
    @(posedge ref_clk) disable iff (!resetn)
    wr_en && wr_addr == DMSCP_PAGE_REG_ADDR && wr_data[2:0] == 3'h5 |=> eq_page_active;
  endproperty
  a_page_switch: assert property (p_page_switch) else $error("page not switched");

  property p_default_page;
    @(posedge ref_clk) disable iff (!resetn)
    $rose(strap_done_r) |-> !eq_page_active && page_r == DMSCP_PAGE_RESET;
  endproperty
  a_default_page: assert property (p_default_page) else $error("start page wrong");

  property p_spi_reply;
    @(posedge ref_clk) disable iff (!resetn)
    spi_rd |=> reply_r[16:8] == {1'b1, $past(frame_word[15:8])} &&
      reply_tog_r != $past(reply_tog_r);
  endproperty
  a_spi_reply: assert property (p_spi_reply) else $error("read reply wrong");

endmodule : dmscp_top

// ### tb/dmscp_host_model.sv
// Host model: two-wire and SPI master driving the port's pins
`timescale 1ns/1ps
module dmscp_host_model (
  // System clock used to pace two-wire phases
  input  wire logic ref_clk,
  // Two-wire pins
  input  wire logic sda_oe,
  input  wire logic sda_o,
  output logic      scl_i,
  output logic      sda_i,
  // SPI pins
  output logic      sck,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso_o,
  input  wire logic miso_oe
);
  logic sda_h;

  // Wired-AND with pull-up: device can only pull low
  assign sda_i = sda_oe ? (sda_h & sda_o) : sda_h;

  // Idle bus levels; the SPI clock stands still outside frames
  initial begin
    scl_i = 1'b1;
    sda_h = 1'b1;
    sck   = 1'b0;
    ss_n  = 1'b1;
    mosi  = 1'b0;
  end

  // Wait n system clocks, then step off the edge
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  // Start or repeated start: data falls while clock high
  task automatic i2c_start();
    sda_h = 1'b1;
    hold(5);
    scl_i = 1'b1;
    hold(5);
    sda_h = 1'b0;
    hold(5);
    scl_i = 1'b0;
    hold(5);
  endtask

  // Stop: data rises while clock high
  task automatic i2c_stop();
    sda_h = 1'b0;
    hold(5);
    scl_i = 1'b1;
    hold(5);
    sda_h = 1'b1;
    hold(10);
  endtask

  // Nine clocks per byte, MSB first; the ninth carries the acknowledge
  task automatic i2c_byte(input logic [7:0] tx, input logic mack, output logic [8:0] rx);
    logic [8:0] w;
    w = {tx, mack};
    for (int i = 8; i >= 0; i--) begin
      sda_h = w[i];
      hold(5);
      scl_i = 1'b1;
      hold(5);
      rx[i] = sda_i;
      hold(5);
      scl_i = 1'b0;
      hold(5);
    end
  endtask

  // One 17-bit frame under select, MSB first, data set before each rise
  task automatic spi_frame(input logic [16:0] tx, output logic [16:0] rx, output logic en);
    ss_n = 1'b0;
    #1;
    en = miso_oe;
    #12;
    for (int i = 16; i >= 0; i--) begin
      mosi = tx[i];
      #27;
      rx[i] = miso_o;
      #13;
      sck = 1'b1;
      #40;
      sck = 1'b0;
    end
    #40;
    ss_n = 1'b1;
    // Deselected data line does not keep its last value
    mosi = ~mosi;
    hold(12);
  endtask
endmodule // dmscp_host_model

// ### tb/dmscp_top_tb.sv
// Self-checking bench for the dual-mode serial configuration port
`timescale 1ns/1ps
module dmscp_top_tb;
  import dmscp_pkg::*;
  logic        ref_clk;
  logic        resetn;
  logic [1:0]  mode_strap;
  logic [1:0]  slave_id_strap_a;
  logic [1:0]  slave_id_strap_b;
  logic        scl_i;
  logic        sda_i;
  logic        sda_oe;
  logic        sda_o;
  logic        sck;
  logic        ss_n;
  logic        mosi;
  logic        miso_o;
  logic        miso_oe;
  logic        smbus_mode;
  logic        spi_mode;
  logic        low_power;
  logic        eq_page_active;
  logic [6:0]  sid;
  logic [8:0]  rx9;
  logic [16:0] rx17;
  logic        en;
  int          failures;
  int          check_count;
  logic [3:0]  mode_exp [4] = '{4'h8, 4'h0, 4'h4, 4'h6};
  logic [7:0]  pg_val [4] = '{8'h05, 8'h01, 8'h06, 8'h05};
  logic        pg_exp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  dmscp_top u_dut (
    .ref_clk, .resetn, .mode_strap, .slave_id_strap_a, .slave_id_strap_b,
    .scl_i, .sda_i, .sda_o, .sda_oe, .sck, .ss_n, .mosi, .miso_o, .miso_oe,
    .smbus_mode, .spi_mode, .low_power, .eq_page_active
  );

  dmscp_host_model u_host (
    .ref_clk, .sda_oe, .sda_o, .scl_i, .sda_i, .sck, .ss_n, .mosi, .miso_o, .miso_oe
  );

  // 25 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Compare one result and count it
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Power-up reset with new strap levels
  task automatic rst(input logic [1:0] m, input logic [1:0] a, input logic [1:0] b);
    resetn = 1'b0;
    mode_strap = m;
    slave_id_strap_a = a;
    slave_id_strap_b = b;
    u_host.hold(10);
    chk({sda_oe, sda_o, miso_oe, smbus_mode, spi_mode, low_power}, 6'h00);
    resetn = 1'b1;
    u_host.hold(12);
  endtask

  // Two-wire register write; ea is the acknowledge level expected on each byte
  task automatic tw_write(input logic [7:0] ra, input logic [7:0] d, input logic ea);
    u_host.i2c_start();
    u_host.i2c_byte({sid, 1'b0}, 1'b1, rx9);
    chk(rx9[0], ea);
    u_host.i2c_byte(ra, 1'b1, rx9);
    chk(rx9[0], ea);
    u_host.i2c_byte(d, 1'b1, rx9);
    chk(rx9[0], ea);
    u_host.i2c_stop();
  endtask

  // Two-wire read: pointer write, restart, one byte left unacknowledged
  task automatic tw_read(input logic [7:0] ra, input logic [7:0] e);
    u_host.i2c_start();
    u_host.i2c_byte({sid, 1'b0}, 1'b1, rx9);
    u_host.i2c_byte(ra, 1'b1, rx9);
    chk(rx9[0], 1'b0);
    u_host.i2c_start();
    u_host.i2c_byte({sid, 1'b1}, 1'b1, rx9);
    chk(rx9[0], 1'b0);
    u_host.i2c_byte(8'hFF, 1'b1, rx9);
    u_host.i2c_stop();
    chk(rx9[8:1], e);
  endtask

  // Watchdog: about three times the expected run of some 16,000 clocks
  initial begin
    #2_000_000;
    failures++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    failures = 0;
    check_count = 0;
    resetn = 1'b0;
    mode_strap = 2'h0;
    slave_id_strap_a = 2'h0;
    slave_id_strap_b = 2'h0;
    sid = 7'h00;
    // Every mode strap level
    for (int m = 0; m < 4; m++) begin
      rst(m[1:0], 2'h0, 2'h0);
      chk({smbus_mode, spi_mode, low_power, eq_page_active}, mode_exp[m]);
    end
    // All sixteen strap pairs: own address acked, neighbour not
    for (int k = 0; k < 16; k++) begin
      rst(DMSCP_LVL_L, k[3:2], k[1:0]);
      sid = 7'h1D + 7'(k);
      u_host.i2c_start();
      u_host.i2c_byte({sid, 1'b0}, 1'b1, rx9);
      chk(rx9[0], 1'b0);
      u_host.i2c_start();
      u_host.i2c_byte({sid + 7'h01, 1'b0}, 1'b1, rx9);
      chk(rx9[0], 1'b1);
      u_host.i2c_stop();
    end
    tw_write(8'h10, 8'hA5, 1'b0);
    tw_read(8'h10, 8'hA5);
    sid = sid + 7'h01;
    tw_write(8'h10, 8'h00, 1'b1);
    sid = sid - 7'h01;
    tw_read(8'h10, 8'hA5);
    // Page select values, valid and invalid
    foreach (pg_val[i]) begin
      tw_write(8'hFF, pg_val[i], 1'b0);
      chk(eq_page_active, pg_exp[i]);
    end
    tw_write(8'h10, 8'h3C, 1'b0);
    tw_write(8'hFF, 8'h00, 1'b0);
    tw_read(8'h10, 8'hA5);
    tw_write(8'hFF, 8'h05, 1'b0);
    tw_read(8'h10, 8'h3C);
    // SPI mode; strap moved after power-up has no effect
    rst(DMSCP_LVL_F, 2'h0, 2'h0);
    mode_strap = DMSCP_LVL_L;
    u_host.hold(20);
    chk({smbus_mode, spi_mode}, 2'h1);
    chk(miso_oe, 1'b0);
    u_host.spi_frame({1'b0, 8'h20, 8'h5A}, rx17, en);
    chk(en, 1'b1);
    chk(miso_oe, 1'b0);
    u_host.spi_frame({1'b1, 8'h20, 8'hFF}, rx17, en);
    chk(rx17, {1'b0, 8'h20, 8'h5A});
    u_host.spi_frame(17'h1_FFFF, rx17, en);
    chk(rx17, {1'b1, 8'h20, 8'h5A});
    u_host.spi_frame({1'b0, 8'hFF, 8'h05}, rx17, en);
    chk(rx17, {1'b1, 8'hFF, 8'h00});
    chk(eq_page_active, 1'b1);
    report_and_stop();
  end
endmodule // dmscp_top_tb
